//--- dea_map.svh
`ifndef DEA_MAP_SVH
`define DEA_MAP_SVH

// ==========================================
// Direct special function register offsets, sector 0
`define DEA_OFS_ADDRESS 8'h0_0A0
`define DEA_OFS_DATA 8'h0_0A1
`define DEA_OFS_PTR1_LOW 8'h0_0A2
`define DEA_OFS_PTR1_HIGH 8'h0_0A3
`define DEA_OFS_PTR2_LOW 8'h0_0A4
`define DEA_OFS_PTR2_HIGH 8'h0_0A5
`define DEA_OFS_PORT1 8'h0_0A6
`define DEA_OFS_PORT2 8'h0_0A7
`define DEA_OFS_IRQ_CTRL 8'h0_0A8

// ==========================================
// Control register, reachable only through a pointer
`define DEA_CTL_PTR_LOW 8'h0_040
`define DEA_CTL_PTR_HIGH 8'h0_001

// ==========================================
// Field positions
`define DEA_BIT_RD_LAUNCH 0
`define DEA_BIT_RD_PERMIT 1
`define DEA_BIT_WR_LAUNCH 2
`define DEA_BIT_WR_PERMIT 3
`define DEA_BIT_GIE 0
`define DEA_BIT_NIE 1
`define DEA_BIT_NIF 2
`define DEA_ADDR_W 6
`define DEA_DATA_W 8

// ==========================================
// Reset values
`define DEA_RST_ADDRESS 6'h0_000
`define DEA_RST_DATA 8'h0_000
`define DEA_RST_PTR 8'h0_000

`endif

//--- dea_pkg.sv
package dea_pkg;

	typedef enum logic [1:0] {
		DEA_IDLE = 2'b00,
		DEA_WRITING = 2'b01,
		DEA_READING = 2'b10
	} dea_phase_t;

	typedef struct packed {
		logic sel;
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dea_sfr_req_t;

	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic wr_start;
		logic rd_start;
	} dea_arr_req_t;

	typedef struct packed {
		logic [7:0] rdata;
		logic wr_done;
		logic rd_done;
	} dea_arr_rsp_t;

	typedef struct packed {
		dea_phase_t phase;
		logic [5:0] nvm_address;
		logic [7:0] nvm_data;
		logic write_permit;
		logic wr_launch;
		logic read_permit;
		logic rd_launch;
		logic [7:0] pointer1_low;
		logic [7:0] pointer1_high;
		logic [7:0] pointer2_low;
		logic [7:0] pointer2_high;
		logic global_irq_enable;
		logic nvm_irq_enable;
		logic nvm_irq_flag;
		logic [7:0] sfr_rdata;
		logic wr_start;
		logic rd_start;
		logic vector_req;
	} dea_state_t;

endpackage

//--- dea_ctrl.sv
// Summary of operation
// - Sixty-four byte store, addresses 0 to 63, one byte per access.
// - Store reached only via address, data and one control register.
// - Control sits at 40H of sector one, only via pointer and port.
// - Address register six bits, resets zero, upper two bits read zero.
// - Data register eight bits, resets zero, carries write and read data.
// - Write-permit bit 3 allows writes; cleared means no write cycle.
// - Write-launch bit 2 starts only with permit; hardware clears at end.
// - Read-permit bit 1 allows reads; cleared means reads inhibited.
// - Read-launch bit 0 starts only with permit; hardware clears at end.
// - After a read the data register holds the byte until next operation.
// - Write cycle timed by array timer; completion after variable clocks.
// - Reset clears write-permit and both pointer high bytes.
// - End of write sets the interrupt flag regardless of enables; enable bits gate the vector.
// - Vector only with global and local enables set and stack not full.
// - Servicing the interrupt clears the flag automatically.
`include "dea_map.svh"
`timescale 1ns/100ps
`default_nettype none

module dea_ctrl (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Core register port
	input wire dea_pkg::dea_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	// Interrupt handshake with core
	input wire logic stack_full,
	input wire logic irq_ack,
	output logic vector_req,
	// Non-volatile array
	output dea_pkg::dea_arr_req_t arr_req,
	input wire dea_pkg::dea_arr_rsp_t arr_rsp
);
	import dea_pkg::*;

	// ==========================================
	// Decode
	// Resolves a direct offset to a 16-bit target; ports follow their pointer
	function automatic logic [15:0] target_of(input logic [7:0] ofs, input dea_state_t s);
		logic [15:0] t;
		t = {8'h0_000, ofs};
		if (ofs == `DEA_OFS_PORT1) begin
			t = {s.pointer1_high, s.pointer1_low};
		end else if (ofs == `DEA_OFS_PORT2) begin
			t = {s.pointer2_high, s.pointer2_low};
		end
		return t;
	endfunction

	localparam logic [15:0] CTL_TARGET = {`DEA_CTL_PTR_HIGH, `DEA_CTL_PTR_LOW};

	dea_state_t st_reg;
	dea_state_t st_next;
	logic [15:0] tgt;
	logic busy;
	logic wr_go;
	logic rd_go;
	logic wr_end;
	logic rd_end;

	assign tgt = target_of(sfr_req.addr, st_reg);
	assign busy = (st_reg.phase != DEA_IDLE);
	assign wr_end = (st_reg.phase == DEA_WRITING) && arr_rsp.wr_done;
	assign rd_end = (st_reg.phase == DEA_READING) && arr_rsp.rd_done;

	// ==========================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.wr_start = 1'b0;
		st_next.rd_start = 1'b0;
		wr_go = 1'b0;
		rd_go = 1'b0;

		// Register writes
		if (sfr_req.sel && sfr_req.wr) begin
			case (tgt)
				{8'h0_000, `DEA_OFS_ADDRESS}: begin
					if (!busy) begin
						st_next.nvm_address = sfr_req.wdata[5:0];
					end
				end
				{8'h0_000, `DEA_OFS_DATA}: begin
					if (!busy) begin
						st_next.nvm_data = sfr_req.wdata;
					end
				end
				{8'h0_000, `DEA_OFS_PTR1_LOW}: st_next.pointer1_low = sfr_req.wdata;
				{8'h0_000, `DEA_OFS_PTR1_HIGH}: st_next.pointer1_high = sfr_req.wdata;
				{8'h0_000, `DEA_OFS_PTR2_LOW}: st_next.pointer2_low = sfr_req.wdata;
				{8'h0_000, `DEA_OFS_PTR2_HIGH}: st_next.pointer2_high = sfr_req.wdata;
				{8'h0_000, `DEA_OFS_IRQ_CTRL}: begin
					st_next.global_irq_enable = sfr_req.wdata[`DEA_BIT_GIE];
					st_next.nvm_irq_enable = sfr_req.wdata[`DEA_BIT_NIE];
					st_next.nvm_irq_flag = sfr_req.wdata[`DEA_BIT_NIF];
				end
				CTL_TARGET: begin
					st_next.write_permit = sfr_req.wdata[`DEA_BIT_WR_PERMIT];
					st_next.read_permit = sfr_req.wdata[`DEA_BIT_RD_PERMIT];
					// Permit must already be set; a launch in the same write is lost
					if (!busy) begin
						wr_go = sfr_req.wdata[`DEA_BIT_WR_LAUNCH] && st_reg.write_permit;
						// Write wins if software breaks the one-launch limit
						rd_go = sfr_req.wdata[`DEA_BIT_RD_LAUNCH] && st_reg.read_permit
							&& !wr_go;
					end
				end
				default: begin
				end
			endcase
		end

		// Cycle sequencing
		case (st_reg.phase)
			DEA_IDLE: begin
				if (wr_go) begin
					st_next.phase = DEA_WRITING;
					st_next.wr_launch = 1'b1;
					st_next.wr_start = 1'b1;
				end else if (rd_go) begin
					st_next.phase = DEA_READING;
					st_next.rd_launch = 1'b1;
					st_next.rd_start = 1'b1;
				end
			end
			DEA_WRITING: begin
				// Array timer is free running; wait as long as it takes
				if (arr_rsp.wr_done) begin
					st_next.phase = DEA_IDLE;
					st_next.wr_launch = 1'b0;
				end
			end
			DEA_READING: begin
				if (arr_rsp.rd_done) begin
					st_next.phase = DEA_IDLE;
					st_next.rd_launch = 1'b0;
					st_next.nvm_data = arr_rsp.rdata;
				end
			end
			default: begin
				st_next.phase = DEA_IDLE;
				st_next.wr_launch = 1'b0;
				st_next.rd_launch = 1'b0;
			end
		endcase

		// Flag: end of write beats a clear in the same cycle
		if (irq_ack) begin
			st_next.nvm_irq_flag = 1'b0;
		end
		if (wr_end) begin
			st_next.nvm_irq_flag = 1'b1;
		end
		st_next.vector_req = st_reg.global_irq_enable && st_reg.nvm_irq_enable
			&& st_reg.nvm_irq_flag && !stack_full && !irq_ack;

		// Registered read data; unmapped targets answer zero
		st_next.sfr_rdata = 8'h0_000;
		if (sfr_req.sel && sfr_req.rd) begin
			case (tgt)
				{8'h0_000, `DEA_OFS_ADDRESS}: st_next.sfr_rdata = {2'b00, st_reg.nvm_address};
				{8'h0_000, `DEA_OFS_DATA}: st_next.sfr_rdata = st_reg.nvm_data;
				{8'h0_000, `DEA_OFS_PTR1_LOW}: st_next.sfr_rdata = st_reg.pointer1_low;
				{8'h0_000, `DEA_OFS_PTR1_HIGH}: st_next.sfr_rdata = st_reg.pointer1_high;
				{8'h0_000, `DEA_OFS_PTR2_LOW}: st_next.sfr_rdata = st_reg.pointer2_low;
				{8'h0_000, `DEA_OFS_PTR2_HIGH}: st_next.sfr_rdata = st_reg.pointer2_high;
				{8'h0_000, `DEA_OFS_IRQ_CTRL}: begin
					st_next.sfr_rdata = {5'b00000, st_reg.nvm_irq_flag,
						st_reg.nvm_irq_enable, st_reg.global_irq_enable};
				end
				CTL_TARGET: begin
					st_next.sfr_rdata = {4'h0, st_reg.write_permit, st_reg.wr_launch,
						st_reg.read_permit, st_reg.rd_launch};
				end
				default: st_next.sfr_rdata = 8'h0_000;
			endcase
		end
	end

	// ==========================================
	// State register
	always_ff @(posedge mclk) begin
		if (reset) begin
			st_reg <= '0;
			st_reg.phase <= DEA_IDLE;
			st_reg.nvm_address <= `DEA_RST_ADDRESS;
			st_reg.nvm_data <= `DEA_RST_DATA;
			st_reg.pointer1_high <= `DEA_RST_PTR;
			st_reg.pointer2_high <= `DEA_RST_PTR;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================
	// Outputs, all straight from flip-flops
	assign sfr_rdata = st_reg.sfr_rdata;
	assign vector_req = st_reg.vector_req;
	assign arr_req.addr = st_reg.nvm_address;
	assign arr_req.wdata = st_reg.nvm_data;
	assign arr_req.wr_start = st_reg.wr_start;
	assign arr_req.rd_start = st_reg.rd_start;

	// ==========================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	addr_upper_zero_a: assert property (
		sfr_req.sel && sfr_req.rd && sfr_req.addr == `DEA_OFS_ADDRESS |=> sfr_rdata[7:6] == 2'b00
	) else $error("address register upper bits not zero");

	wr_needs_permit_a: assert property (
		st_reg.phase == DEA_IDLE && !st_reg.write_permit |=> !arr_req.wr_start
	) else $error("write cycle started without permit");

	rd_needs_permit_a: assert property (
		st_reg.phase == DEA_IDLE && !st_reg.read_permit |=> !arr_req.rd_start
	) else $error("read cycle started without permit");

	wr_start_pulse_a: assert property (
		arr_req.wr_start |-> st_reg.phase == DEA_WRITING && st_reg.wr_launch
			##1 !arr_req.wr_start
	) else $error("write start not a single pulse into a write cycle");

	wr_end_flag_a: assert property (
		wr_end |=> !st_reg.wr_launch && st_reg.nvm_irq_flag && st_reg.phase == DEA_IDLE
	) else $error("write end did not clear launch and set flag");

	rd_end_data_a: assert property (
		rd_end |=> st_reg.nvm_data == $past(arr_rsp.rdata) && !st_reg.rd_launch
	) else $error("read end did not load data or clear launch");

	busy_hold_a: assert property (
		busy && !wr_end && !rd_end |=> $stable(st_reg.nvm_address) && $stable(st_reg.nvm_data)
	) else $error("address or data changed during a cycle");

	vector_gate_a: assert property (
		vector_req |-> $past(st_reg.global_irq_enable) && $past(st_reg.nvm_irq_enable)
			&& $past(st_reg.nvm_irq_flag) && !$past(stack_full)
	) else $error("vector raised without all conditions");

	ack_clears_a: assert property (
		irq_ack && !wr_end |=> !st_reg.nvm_irq_flag ##1 !vector_req
	) else $error("service did not clear flag");

	reset_protect_a: assert property (
		$past(reset) |-> !st_reg.write_permit && st_reg.pointer1_high == 8'h0_000
			&& st_reg.pointer2_high == 8'h0_000
	) else $error("reset left write path open");

	rd_data_path_a: assert property (
		sfr_req.sel && sfr_req.rd && sfr_req.addr == `DEA_OFS_DATA
			|=> sfr_rdata == $past(st_reg.nvm_data)
	) else $error("data register read back wrong");

	rd_addr_path_a: assert property (
		sfr_req.sel && sfr_req.rd && sfr_req.addr == `DEA_OFS_ADDRESS
			|=> sfr_rdata == {2'b00, $past(st_reg.nvm_address)}
	) else $error("address register read back wrong");

	ctl_readback_a: assert property (
		sfr_req.sel && sfr_req.rd && tgt == CTL_TARGET |=> sfr_rdata[7:4] == 4'h0
			&& sfr_rdata[3] == $past(st_reg.write_permit)
			&& sfr_rdata[0] == $past(st_reg.rd_launch)
	) else $error("control register read back wrong");

	rdata_idle_zero_a: assert property (
		!(sfr_req.sel && sfr_req.rd) |=> sfr_rdata == 8'h0_000
	) else $error("read data not zero without a read");

	direct_ctl_blocked_a: assert property (
		sfr_req.sel && sfr_req.wr && sfr_req.addr == `DEA_CTL_PTR_LOW
			|=> $stable(st_reg.write_permit) && $stable(st_reg.read_permit)
	) else $error("control reached without pointer");

	wr_permit_set_a: assert property (
		sfr_req.sel && sfr_req.wr && tgt == CTL_TARGET && sfr_req.wdata[`DEA_BIT_WR_PERMIT]
			|=> st_reg.write_permit
	) else $error("write permit not set");

	wr_permit_clear_a: assert property (
		sfr_req.sel && sfr_req.wr && tgt == CTL_TARGET && !sfr_req.wdata[`DEA_BIT_WR_PERMIT]
			|=> !st_reg.write_permit
	) else $error("write permit not cleared");

	rd_permit_set_a: assert property (
		sfr_req.sel && sfr_req.wr && tgt == CTL_TARGET && sfr_req.wdata[`DEA_BIT_RD_PERMIT]
			|=> st_reg.read_permit
	) else $error("read permit not set");

	rd_permit_clear_a: assert property (
		sfr_req.sel && sfr_req.wr && tgt == CTL_TARGET && !sfr_req.wdata[`DEA_BIT_RD_PERMIT]
			|=> !st_reg.read_permit
	) else $error("read permit not cleared");

	wr_launch_go_a: assert property (
		st_reg.phase == DEA_IDLE && st_reg.write_permit && sfr_req.sel && sfr_req.wr
			&& tgt == CTL_TARGET && sfr_req.wdata[`DEA_BIT_WR_LAUNCH]
			|=> arr_req.wr_start && st_reg.phase == DEA_WRITING
	) else $error("permitted write launch did not start");

	rd_launch_go_a: assert property (
		st_reg.phase == DEA_IDLE && st_reg.read_permit && sfr_req.sel && sfr_req.wr
			&& tgt == CTL_TARGET && sfr_req.wdata[`DEA_BIT_RD_LAUNCH]
			&& !sfr_req.wdata[`DEA_BIT_WR_LAUNCH]
			|=> arr_req.rd_start && st_reg.phase == DEA_READING
	) else $error("permitted read launch did not start");

	one_launch_a: assert property (
		!(st_reg.wr_launch && st_reg.rd_launch)
	) else $error("both launch bits set");

	busy_no_start_a: assert property (
		busy |=> !arr_req.wr_start && !arr_req.rd_start
	) else $error("cycle started while busy");

	rd_no_flag_a: assert property (
		rd_end && !irq_ack && !(sfr_req.sel && sfr_req.wr) |=> $stable(st_reg.nvm_irq_flag)
	) else $error("read end touched the flag");

	vector_stack_a: assert property (
		stack_full |=> !vector_req
	) else $error("vector raised with stack full");

	vector_rise_a: assert property (
		st_reg.global_irq_enable && st_reg.nvm_irq_enable && st_reg.nvm_irq_flag
			&& !stack_full && !irq_ack |=> vector_req
	) else $error("vector not raised");

	rd_start_pulse_a: assert property (
		arr_req.rd_start |-> st_reg.phase == DEA_READING && st_reg.rd_launch
			##1 !arr_req.rd_start
	) else $error("read start not a single pulse into a read cycle");

	reset_regs_a: assert property (
		$past(reset) |-> st_reg.nvm_address == `DEA_RST_ADDRESS
			&& st_reg.nvm_data == `DEA_RST_DATA && !st_reg.read_permit
	) else $error("reset left address, data or read permit set");

endmodule

`default_nettype wire

//--- dea_arr_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Array model, write time drifts per cycle
module dea_arr_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Array link
	input wire dea_pkg::dea_arr_req_t arr_req,
	output dea_pkg::dea_arr_rsp_t arr_rsp
);
	import dea_pkg::*;
	logic [7:0] mem [0:63];
	logic [5:0] adr;
	logic [7:0] dat;
	int wcnt;
	int rcnt;
	int wlen;
	// Idle read bus toggles so a stale byte never looks valid
	always @(posedge mclk) begin
		arr_rsp.wr_done <= 1'b0;
		arr_rsp.rd_done <= 1'b0;
		arr_rsp.rdata <= ~arr_rsp.rdata;
		if (reset) begin
			wcnt <= 0;
			rcnt <= 0;
			wlen <= 20;
			arr_rsp <= '0;
		end else if (arr_req.wr_start) begin
			adr <= arr_req.addr;
			dat <= arr_req.wdata;
			wcnt <= wlen;
			wlen <= wlen + 5;
		end else if (arr_req.rd_start) begin
			adr <= arr_req.addr;
			rcnt <= 2;
		end else if (wcnt == 1) begin
			mem[adr] <= dat;
			arr_rsp.wr_done <= 1'b1;
			wcnt <= 0;
		end else if (wcnt > 1) begin
			wcnt <= wcnt - 1;
		end else if (rcnt == 1) begin
			arr_rsp.rdata <= mem[adr];
			arr_rsp.rd_done <= 1'b1;
			rcnt <= 0;
		end else if (rcnt > 1) begin
			rcnt <= rcnt - 1;
		end
	end
endmodule

`default_nettype wire

//--- tb_data_eeprom_access_controller.sv
`include "dea_map.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_data_eeprom_access_controller;
	import dea_pkg::*;
	localparam logic [7:0] a_adr = `DEA_OFS_ADDRESS;
	localparam logic [7:0] a_dat = `DEA_OFS_DATA;
	localparam logic [7:0] a_p1 = `DEA_OFS_PORT1;
	localparam logic [7:0] a_irq = `DEA_OFS_IRQ_CTRL;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic stack_full = 1'b0;
	logic irq_ack = 1'b0;
	dea_sfr_req_t sfr_req = '0;
	logic [7:0] sfr_rdata;
	logic vector_req;
	dea_arr_req_t arr_req;
	dea_arr_rsp_t arr_rsp;
	int err_count = 0;
	int check_count = 0;
	int starts = 0;
	logic [7:0] v;

	always #20 mclk = ~mclk;
	always @(posedge mclk) if (arr_req.wr_start | arr_req.rd_start) starts <= starts + 1;

	dea_ctrl DUT (
		.mclk(mclk),
		.reset(reset),
		.sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata),
		.stack_full(stack_full),
		.irq_ack(irq_ack),
		.vector_req(vector_req),
		.arr_req(arr_req),
		.arr_rsp(arr_rsp)
	);
	dea_arr_model arr (
		.mclk(mclk),
		.reset(reset),
		.arr_req(arr_req),
		.arr_rsp(arr_rsp)
	);

	// ==========================================
	// Access tasks
	task automatic stop_test();
		if (err_count == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Idle cycle after each access keeps strobes single pulses
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		sfr_req = '{sel: 1'b1, wr: w, rd: !w, addr: a, wdata: d};
		@(negedge mclk);
		v = sfr_rdata;
		sfr_req = '0;
		@(negedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		chk(v, exp);
	endtask
	task automatic poll(input int b);
		for (int i = 0; i < 300; i++) begin
			acc(1'b0, a_p1, 8'h00);
			if (v[b] === 1'b0) return;
		end
		err_count++;
		stop_test();
	endtask

	// ==========================================
	// Sequence
	initial begin
		repeat (4) @(negedge mclk);
		reset = 1'b0;
		rd(a_adr, 8'h00);
		rd(a_dat, 8'h00);
		rd(`DEA_OFS_PTR1_HIGH, 8'h00);
		rd(a_p1, 8'h00);
		acc(1'b1, `DEA_CTL_PTR_LOW, 8'h0F);
		rd(`DEA_CTL_PTR_LOW, 8'h00);
		acc(1'b1, `DEA_OFS_PTR1_LOW, 8'h40);
		acc(1'b1, `DEA_OFS_PTR1_HIGH, 8'h01);
		acc(1'b1, `DEA_OFS_PTR2_LOW, 8'h40);
		acc(1'b1, `DEA_OFS_PTR2_HIGH, 8'h01);
		rd(a_p1, 8'h00);
		acc(1'b1, a_adr, 8'hFF);
		rd(a_adr, 8'h3F);
		acc(1'b1, a_p1, 8'h04);
		rd(`DEA_OFS_PORT2, 8'h00);
		acc(1'b1, a_p1, 8'h01);
		rd(a_p1, 8'h00);
		chk(starts[7:0], 8'h00);
		acc(1'b1, a_irq, 8'h03);
		stack_full = 1'b1;
		acc(1'b1, a_irq, 8'h02);
		acc(1'b1, a_dat, 8'hA5);
		acc(1'b1, a_p1, 8'h08);
		acc(1'b1, a_p1, 8'h0C);
		acc(1'b1, a_irq, 8'h03);
		rd(a_p1, 8'h0C);
		acc(1'b1, a_adr, 8'h05);
		acc(1'b1, a_dat, 8'h11);
		acc(1'b1, a_p1, 8'h08);
		rd(a_adr, 8'h3F);
		rd(a_dat, 8'hA5);
		poll(2);
		rd(a_irq, 8'h07);
		chk({7'h00, vector_req}, 8'h00);
		stack_full = 1'b0;
		@(negedge mclk);
		chk({7'h00, vector_req}, 8'h01);
		irq_ack = 1'b1;
		@(negedge mclk);
		irq_ack = 1'b0;
		chk({7'h00, vector_req}, 8'h00);
		rd(a_irq, 8'h03);
		acc(1'b1, a_p1, 8'h02);
		acc(1'b1, a_p1, 8'h03);
		poll(0);
		rd(a_p1, 8'h02);
		rd(a_dat, 8'hA5);
		acc(1'b1, a_adr, 8'h00);
		acc(1'b1, a_dat, 8'h5A);
		acc(1'b1, a_p1, 8'h08);
		acc(1'b1, a_p1, 8'h0C);
		poll(2);
		acc(1'b1, a_p1, 8'h02);
		acc(1'b1, a_p1, 8'h03);
		poll(0);
		rd(a_dat, 8'h5A);
		acc(1'b1, a_adr, 8'h3F);
		acc(1'b1, a_p1, 8'h03);
		poll(0);
		rd(a_dat, 8'hA5);
		acc(1'b1, a_p1, 8'h00);
		acc(1'b1, a_p1, 8'h01);
		rd(a_p1, 8'h00);
		rd(a_dat, 8'hA5);
		chk(starts[7:0], 8'h05);
		stop_test();
	end
endmodule

`default_nettype wire
